// ===== lnbc_pkg.sv
package lnbc_pkg;

    // System register bit positions.
    localparam int unsigned POS_CLAMP = 7;
    localparam int unsigned POS_TX = 6;
    localparam int unsigned POS_MODE = 5;
    localparam int unsigned POS_COMP = 4;
    localparam int unsigned POS_LEVEL = 3;
    localparam int unsigned POS_EN = 2;
    localparam int unsigned POS_OTF = 1;
    localparam int unsigned POS_OLF = 0;
    // Control field index inside the six writable bits (bit 7..2 maps to 5..0).
    localparam int unsigned CTL_CLAMP = POS_CLAMP - POS_EN;
    localparam int unsigned CTL_TX = POS_TX - POS_EN;
    localparam int unsigned CTL_MODE = POS_MODE - POS_EN;
    localparam int unsigned CTL_COMP = POS_COMP - POS_EN;
    localparam int unsigned CTL_LEVEL = POS_LEVEL - POS_EN;
    localparam int unsigned CTL_EN = 0;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [7:0] SR_RESET = 8'h00;

    // Bus address: base with the address-select value in the low bits.
    localparam logic [6:0] I2C_BASE_ADDR = 7'h08;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Protection timing at the system clock rate.
    localparam int unsigned CLK_FREQ_KHZ = 200000;
    localparam int unsigned OFF_TIME_MS = 900;
    localparam int unsigned PERIOD_TIME_MS = 990;
    localparam int unsigned OFF_CYCLES = OFF_TIME_MS * CLK_FREQ_KHZ;
    localparam int unsigned ON_CYCLES = (PERIOD_TIME_MS - OFF_TIME_MS) * CLK_FREQ_KHZ;
    localparam int unsigned TIMER_W = 28;

    // Pins entering from outside the clock domain.
    typedef struct packed {
        logic scl;
        logic sda;
        logic tonePin;
        logic overload;
        logic overtemp;
        logic uvlo;
        logic [1:0] addrSel;
    } lnbc_pins_t;
    localparam int unsigned PIN_W = $bits(lnbc_pins_t);
    localparam lnbc_pins_t PINS_IDLE = '{scl: 1'h1, sda: 1'h1, tonePin: 1'h0, overload: 1'h0,
                                         overtemp: 1'h0, uvlo: 1'h0, addrSel: 2'h0};

    // Enables toward the analog power blocks.
    typedef struct packed {
        logic dcdcEnable;
        logic regulatorEnable;
        logic toneEnable;
        logic levelHigh;
        logic upConvHigh;
        logic cableComp;
        logic txSwitch;
        logic staticClamp;
    } lnbc_power_t;
    localparam lnbc_power_t POWER_OFF = '0;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ADDR = 3'b001,
        BUS_ADDR_ACK = 3'b010,
        BUS_WRITE = 3'b011,
        BUS_WRITE_ACK = 3'b100,
        BUS_READ = 3'b101,
        BUS_READ_ACK = 3'b110
    } lnbc_bus_state_t;

    typedef enum logic [1:0] {
        PROT_NORMAL = 2'b00,
        PROT_OFF = 2'b01,
        PROT_ON = 2'b10
    } lnbc_prot_state_t;

endpackage : lnbc_pkg

// ===== lnbc_sync.sv
`timescale 1ns/10ps
module lnbc_sync #(
    parameter int unsigned W = lnbc_pkg::PIN_W,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk_sys, // System clock.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic [W-1:0] din, // Asynchronous inputs.
    output logic [W-1:0] dout // Synchronised inputs.
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } lnbc_sync_state_t;

    lnbc_sync_state_t q;
    lnbc_sync_state_t d;

    // Two flip-flops per bit; only the second stage is visible outside.
    always_comb begin
        d = q;
        d.stage1 = din;
        d.stage2 = q.stage1;
    end

    // State register.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q <= '{stage1: RESET_VAL, stage2: RESET_VAL};
        end else begin
            q <= d;
        end
    end

    assign dout = q.stage2;

endmodule : lnbc_sync

// ===== lnbc_supply_ctrl.sv
`timescale 1ns/10ps
module lnbc_supply_ctrl #(
    parameter logic [27:0] OFF_CYCLES = 28'(lnbc_pkg::OFF_CYCLES),
    parameter logic [27:0] ON_CYCLES = 28'(lnbc_pkg::ON_CYCLES)
) (
    input wire logic clk_sys, // System clock, 200 MHz.
    input wire logic reset, // Power-on reset, synchronous, active high.
    input wire logic sclIn, // Bus clock level.
    input wire logic sdaIn, // Bus data level.
    output logic sdaOut, // Bus data drive value, always low.
    output logic sdaOe, // High while the block pulls data low.
    input wire logic tonePin, // Tone enable or level select pin.
    input wire logic overloadIn, // Analog overload indication.
    input wire logic overtempIn, // Analog over-temperature indication.
    input wire logic uvloIn, // Analog undervoltage indication.
    input wire logic [1:0] addrSel, // Address-select level.
    output lnbc_pkg::lnbc_power_t powerCtrl, // Enables toward the power blocks.
    output logic overtempFlag, // Over-temperature flag.
    output logic overloadFlag // Overload flag.
);

    typedef struct packed {
        logic sclPrev;
        logic sdaPrev;
        lnbc_pkg::lnbc_bus_state_t bus;
        logic [2:0] bitCnt;
        logic full;
        logic [7:0] shift;
        logic rw;
        logic ackd;
        logic [5:0] ctrl;
        logic overtemp_flag;
        logic overload_flag;
        lnbc_pkg::lnbc_prot_state_t prot;
        logic [27:0] pcnt;
        logic seen;
        logic sdaOe;
        lnbc_pkg::lnbc_power_t pwr;
    } lnbc_state_t;

    lnbc_state_t q;
    lnbc_state_t d;
    lnbc_pkg::lnbc_pins_t pinsRaw;
    lnbc_pkg::lnbc_pins_t pinsS;
    logic sclRise;
    logic sclFall;
    logic startDet;
    logic stopDet;
    logic commit;
    logic pwrOk;
    logic [6:0] myAddr;
    logic [7:0] srLive;

    // Every pin from outside the domain passes the two-stage synchroniser.
    assign pinsRaw = '{scl: sclIn, sda: sdaIn, tonePin: tonePin, overload: overloadIn,
                       overtemp: overtempIn, uvlo: uvloIn, addrSel: addrSel};

    lnbc_sync #(
        .W(lnbc_pkg::PIN_W),
        .RESET_VAL(lnbc_pkg::PINS_IDLE)
    ) uSync (
        .clk_sys(clk_sys),
        .reset(reset),
        .din(pinsRaw),
        .dout(pinsS)
    );

    // Next-state logic for the bus slave, the register and the protection timer.
    always_comb begin
        d = q;
        commit = 1'h0;
        d.sclPrev = pinsS.scl;
        d.sdaPrev = pinsS.sda;
        // Edges and bus conditions from synchronised samples only.
        sclRise = pinsS.scl && !q.sclPrev;
        sclFall = !pinsS.scl && q.sclPrev;
        startDet = pinsS.scl && q.sclPrev && q.sdaPrev && !pinsS.sda;
        stopDet = pinsS.scl && q.sclPrev && !q.sdaPrev && pinsS.sda;
        myAddr = lnbc_pkg::I2C_BASE_ADDR | {5'h00, pinsS.addrSel};
        srLive = {q.ctrl, q.overtemp_flag, q.overload_flag};

        // Bus slave; lockout silences it entirely.
        if (pinsS.uvlo) begin
            d.bus = lnbc_pkg::BUS_IDLE;
            d.sdaOe = 1'h0;
            d.full = 1'h0;
        end else if (startDet) begin
            d.bus = lnbc_pkg::BUS_ADDR;
            d.bitCnt = 3'h0;
            d.full = 1'h0;
            d.sdaOe = 1'h0;
        end else if (stopDet) begin
            d.bus = lnbc_pkg::BUS_IDLE;
            d.sdaOe = 1'h0;
            d.full = 1'h0;
        end else begin
            unique case (q.bus)
                lnbc_pkg::BUS_IDLE: begin
                    d.bus = lnbc_pkg::BUS_IDLE;
                end
                lnbc_pkg::BUS_ADDR, lnbc_pkg::BUS_WRITE: begin
                    // Shift in eight bits MSB first on rising clock.
                    if (sclRise) begin
                        d.shift = {q.shift[6:0], pinsS.sda};
                        d.bitCnt = q.bitCnt + 3'h1;
                        d.full = (q.bitCnt == lnbc_pkg::LAST_BIT);
                    end else if (sclFall && q.full) begin
                        d.full = 1'h0;
                        if (q.bus == lnbc_pkg::BUS_ADDR) begin
                            if (q.shift[7:1] == myAddr) begin
                                d.sdaOe = 1'h1;
                                d.rw = q.shift[0];
                                d.bus = lnbc_pkg::BUS_ADDR_ACK;
                            end else begin
                                d.bus = lnbc_pkg::BUS_IDLE;
                            end
                        end else begin
                            commit = 1'h1;
                            d.sdaOe = 1'h1;
                            d.bus = lnbc_pkg::BUS_WRITE_ACK;
                        end
                    end
                end
                lnbc_pkg::BUS_ADDR_ACK: begin
                    // End of ninth pulse: release, or present the first read bit.
                    if (sclFall) begin
                        d.bitCnt = 3'h0;
                        if (q.rw) begin
                            d.bus = lnbc_pkg::BUS_READ;
                            d.shift = srLive;
                            d.sdaOe = !srLive[7];
                        end else begin
                            d.bus = lnbc_pkg::BUS_WRITE;
                            d.sdaOe = 1'h0;
                        end
                    end
                end
                lnbc_pkg::BUS_WRITE_ACK: begin
                    if (sclFall) begin
                        d.bus = lnbc_pkg::BUS_WRITE;
                        d.sdaOe = 1'h0;
                        d.bitCnt = 3'h0;
                    end
                end
                lnbc_pkg::BUS_READ: begin
                    // Count bits on rising clock, change data only after falling clock.
                    if (sclRise) begin
                        d.bitCnt = q.bitCnt + 3'h1;
                        d.full = (q.bitCnt == lnbc_pkg::LAST_BIT);
                    end else if (sclFall) begin
                        if (q.full) begin
                            d.full = 1'h0;
                            d.sdaOe = 1'h0;
                            d.bus = lnbc_pkg::BUS_READ_ACK;
                        end else begin
                            d.shift = {q.shift[6:0], 1'h0};
                            d.sdaOe = !q.shift[6];
                        end
                    end
                end
                lnbc_pkg::BUS_READ_ACK: begin
                    // Master ack sends another byte; no ack ends the read.
                    if (sclRise) begin
                        d.ackd = !pinsS.sda;
                    end else if (sclFall) begin
                        if (q.ackd) begin
                            d.bus = lnbc_pkg::BUS_READ;
                            d.shift = srLive;
                            d.sdaOe = !srLive[7];
                            d.bitCnt = 3'h0;
                        end else begin
                            d.bus = lnbc_pkg::BUS_IDLE;
                        end
                    end
                end
                default: begin
                    d.bus = lnbc_pkg::BUS_IDLE;
                    d.sdaOe = 1'h0;
                end
            endcase
        end

        // Only the six control bits are written; lockout zeroes them.
        if (pinsS.uvlo) begin
            d.ctrl = lnbc_pkg::CTRL_RESET;
        end else if (commit) begin
            d.ctrl = q.shift[lnbc_pkg::POS_CLAMP:lnbc_pkg::POS_EN];
        end

        // Over-temperature flag follows the hysteretic indication.
        d.overtemp_flag = pinsS.overtemp && !pinsS.uvlo;

        // Overload handling: static clamp or pulsed off/on cycling.
        if (!q.ctrl[lnbc_pkg::CTL_EN] || pinsS.uvlo) begin
            d.prot = lnbc_pkg::PROT_NORMAL;
            d.pcnt = 28'h0;
            d.seen = 1'h0;
            d.overload_flag = 1'h0;
        end else if (q.ctrl[lnbc_pkg::CTL_CLAMP]) begin
            d.prot = lnbc_pkg::PROT_NORMAL;
            d.pcnt = 28'h0;
            d.overload_flag = pinsS.overload;
        end else begin
            unique case (q.prot)
                lnbc_pkg::PROT_NORMAL: begin
                    d.overload_flag = 1'h0;
                    if (pinsS.overload) begin
                        d.prot = lnbc_pkg::PROT_OFF;
                        d.overload_flag = 1'h1;
                        d.pcnt = 28'h0;
                    end
                end
                lnbc_pkg::PROT_OFF: begin
                    if (q.pcnt == OFF_CYCLES - 28'h1) begin
                        d.prot = lnbc_pkg::PROT_ON;
                        d.pcnt = 28'h0;
                        d.seen = 1'h0;
                    end else begin
                        d.pcnt = q.pcnt + 28'h1;
                    end
                end
                lnbc_pkg::PROT_ON: begin
                    d.seen = q.seen || pinsS.overload;
                    if (q.pcnt == ON_CYCLES - 28'h1) begin
                        d.pcnt = 28'h0;
                        d.seen = 1'h0;
                        if (q.seen || pinsS.overload) begin
                            d.prot = lnbc_pkg::PROT_OFF;
                        end else begin
                            d.prot = lnbc_pkg::PROT_NORMAL;
                            d.overload_flag = 1'h0;
                        end
                    end else begin
                        d.pcnt = q.pcnt + 28'h1;
                    end
                end
                default: begin
                    d.prot = lnbc_pkg::PROT_NORMAL;
                end
            endcase
        end

        // Power-block enables from control bits, flags and the mode pin.
        pwrOk = q.ctrl[lnbc_pkg::CTL_EN] && !q.overtemp_flag && !pinsS.uvlo;
        d.pwr.dcdcEnable = pwrOk;
        d.pwr.regulatorEnable = pwrOk && (q.prot != lnbc_pkg::PROT_OFF);
        d.pwr.toneEnable = pwrOk && !q.ctrl[lnbc_pkg::CTL_MODE] && pinsS.tonePin;
        d.pwr.levelHigh = pwrOk && (q.ctrl[lnbc_pkg::CTL_MODE] ? pinsS.tonePin
                                    : q.ctrl[lnbc_pkg::CTL_LEVEL]);
        d.pwr.upConvHigh = pwrOk && q.ctrl[lnbc_pkg::CTL_LEVEL];
        d.pwr.cableComp = pwrOk && q.ctrl[lnbc_pkg::CTL_COMP];
        d.pwr.txSwitch = pwrOk && q.ctrl[lnbc_pkg::CTL_TX];
        d.pwr.staticClamp = q.ctrl[lnbc_pkg::CTL_CLAMP];
    end

    // State register; power-on clears the whole system register.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q <= '{sclPrev: 1'h1, sdaPrev: 1'h1, bus: lnbc_pkg::BUS_IDLE, bitCnt: 3'h0,
                   full: 1'h0, shift: lnbc_pkg::SR_RESET, rw: 1'h0, ackd: 1'h0,
                   ctrl: lnbc_pkg::CTRL_RESET, overtemp_flag: 1'h0, overload_flag: 1'h0,
                   prot: lnbc_pkg::PROT_NORMAL, pcnt: 28'h0, seen: 1'h0, sdaOe: 1'h0,
                   pwr: lnbc_pkg::POWER_OFF};
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register; data is only ever pulled low.
    assign sdaOut = 1'h0;
    assign sdaOe = q.sdaOe;
    assign powerCtrl = q.pwr;
    assign overtempFlag = q.overtemp_flag;
    assign overloadFlag = q.overload_flag;

    // Checks kept beside the logic they guard.
    chk_reset_clears: assert property (@(posedge clk_sys) reset |=> (q.ctrl == 6'h00
        && !overloadFlag && !overtempFlag)) else $error("register not cleared by reset");
    chk_standby_off: assert property (@(posedge clk_sys) disable iff (reset)
        !q.ctrl[lnbc_pkg::CTL_EN] |=> !powerCtrl.dcdcEnable && !powerCtrl.regulatorEnable
        && !powerCtrl.toneEnable) else $error("power enabled in standby");
    chk_tone_route: assert property (@(posedge clk_sys) disable iff (reset)
        (pwrOk && !q.ctrl[lnbc_pkg::CTL_MODE]) |=> powerCtrl.toneEnable == $past(pinsS.tonePin)
        && powerCtrl.levelHigh == $past(q.ctrl[lnbc_pkg::CTL_LEVEL]))
        else $error("tone mode routing wrong");
    chk_level_pin: assert property (@(posedge clk_sys) disable iff (reset)
        (pwrOk && q.ctrl[lnbc_pkg::CTL_MODE]) |=> powerCtrl.levelHigh == $past(pinsS.tonePin)
        && !powerCtrl.toneEnable) else $error("level mode routing wrong");
    chk_comp_step: assert property (@(posedge clk_sys) disable iff (reset)
        pwrOk |=> powerCtrl.cableComp == $past(q.ctrl[lnbc_pkg::CTL_COMP]))
        else $error("cable compensation wrong");
    chk_overload_trip: assert property (@(posedge clk_sys) disable iff (reset)
        (pwrOk && !pinsS.uvlo && !q.ctrl[lnbc_pkg::CTL_CLAMP] && q.prot == lnbc_pkg::PROT_NORMAL
        && pinsS.overload) |=> overloadFlag && q.prot == lnbc_pkg::PROT_OFF
        ##1 !powerCtrl.regulatorEnable) else $error("overload did not trip");
    chk_off_bound: assert property (@(posedge clk_sys) disable iff (reset)
        q.prot == lnbc_pkg::PROT_OFF |-> q.pcnt < OFF_CYCLES)
        else $error("off period overran");
    chk_off_to_on: assert property (@(posedge clk_sys) disable iff (reset)
        (q.ctrl[lnbc_pkg::CTL_EN] && !q.ctrl[lnbc_pkg::CTL_CLAMP] && !pinsS.uvlo
        && q.prot == lnbc_pkg::PROT_OFF && q.pcnt == OFF_CYCLES - 28'h1)
        |=> q.prot == lnbc_pkg::PROT_ON && q.pcnt == 28'h0) else $error("off end missed");
    chk_clean_on: assert property (@(posedge clk_sys) disable iff (reset)
        (q.ctrl[lnbc_pkg::CTL_EN] && !q.ctrl[lnbc_pkg::CTL_CLAMP] && !pinsS.uvlo
        && q.prot == lnbc_pkg::PROT_ON && q.pcnt == ON_CYCLES - 28'h1 && !q.seen
        && !pinsS.overload) |=> !overloadFlag && q.prot == lnbc_pkg::PROT_NORMAL)
        else $error("flag kept after clean on period");
    chk_static_flag: assert property (@(posedge clk_sys) disable iff (reset)
        (q.ctrl[lnbc_pkg::CTL_EN] && q.ctrl[lnbc_pkg::CTL_CLAMP] && !pinsS.uvlo)
        |=> overloadFlag == $past(pinsS.overload)) else $error("clamp flag wrong");
    chk_overtemp_off: assert property (@(posedge clk_sys) disable iff (reset)
        pinsS.overtemp && !pinsS.uvlo |=> overtempFlag ##1 !powerCtrl.dcdcEnable
        && !powerCtrl.regulatorEnable) else $error("overtemp not handled");
    chk_uvlo_silent: assert property (@(posedge clk_sys) disable iff (reset)
        pinsS.uvlo |=> !sdaOe && q.ctrl == 6'h00) else $error("bus active in lockout");
    chk_sda_stable: assert property (@(posedge clk_sys) disable iff (reset)
        (pinsS.scl && $past(pinsS.scl) && !$past(pinsS.uvlo)) |-> $stable(q.sdaOe))
        else $error("data changed while clock high");
    chk_write_mask: assert property (@(posedge clk_sys) disable iff (reset)
        (commit && !pinsS.uvlo) |=> q.ctrl == $past(q.shift[7:2]))
        else $error("write not stored");

endmodule : lnbc_supply_ctrl

// ===== lnbc_host.sv
`timescale 1ns/10ps
module lnbc_host (
    output logic scl, // Bus clock driven by the host.
    output logic sdaLow, // High while the host pulls data low.
    input wire logic sdaWire // Resolved data line level.
);
    // Half period of the bus clock; 24 ns gives the 48 ns link clock of the bench.
    int halfNs = 24;
    // Idle bus: clock high, data released to the pull-up.
    initial begin
        scl = 1'h1;
        sdaLow = 1'h0;
    end
    // One bit; data moves a quarter phase after the clock falls, never with a clock change.
    task automatic bitIo(input logic b, output logic s);
        #(halfNs / 4);
        sdaLow = !b;
        #(halfNs - halfNs / 4);
        scl = 1'h1;
        #(halfNs / 2);
        s = sdaWire;
        #(halfNs / 2);
        scl = 1'h0;
    endtask : bitIo
    // Eight bits MSB first, then the ninth pulse with data released on a write.
    task automatic byteIo(input logic [7:0] tx, input logic ackBit, output logic [7:0] rx,
                          output logic ackSeen);
        for (int i = 7; i >= 0; i--) begin
            bitIo(tx[i], rx[i]);
        end
        bitIo(ackBit, ackSeen);
    endtask : byteIo
    // Start or stop; every transfer ends with a stop before the next start.
    task automatic frame(input logic isStart);
        #(halfNs / 4);
        sdaLow = 1'h1;
        #(halfNs);
        scl = !isStart;
        if (!isStart) begin
            #(halfNs);
            sdaLow = 1'h0;
            #(halfNs);
        end
    endtask : frame
endmodule : lnbc_host

// ===== tb_lnbc_supply_ctrl.sv
`timescale 1ns/10ps
module tb_lnbc_supply_ctrl;
    logic clk_sys = 1'h0;
    logic reset;
    logic scl, hostLow, sdaOe, sdaOut, otFlag, olFlag;
    logic tonePin, ovl, ovt, uvlo;
    logic [1:0] addrSel;
    lnbc_pkg::lnbc_power_t pwr;
    int errorCnt = 0, testsRun = 0, cycles = 0;
    // Open-drain data line with pull-up.
    wire logic sda = !((sdaOe & !sdaOut) | hostLow);
    lnbc_host i_host (.scl(scl), .sdaLow(hostLow), .sdaWire(sda));
    lnbc_supply_ctrl #(.OFF_CYCLES(28'h28), .ON_CYCLES(28'h4)) i_dut (
        .clk_sys(clk_sys), .reset(reset), .sclIn(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe),
        .tonePin(tonePin), .overloadIn(ovl), .overtempIn(ovt), .uvloIn(uvlo),
        .addrSel(addrSel), .powerCtrl(pwr), .overtempFlag(otFlag), .overloadFlag(olFlag));
    // Clock and hang guard.
    initial begin
        forever #2.5 clk_sys = !clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            errorCnt++;
            completeRun();
        end
    end
    task automatic completeRun();
        if (errorCnt == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : completeRun
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        testsRun++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    // Write transfer; returns address and data acknowledges, 0 meaning taken.
    task automatic wr(input logic [6:0] a, input logic [7:0] d, output logic [1:0] k);
        logic [7:0] rx;
        i_host.frame(1'h1);
        i_host.byteIo({a, 1'h0}, 1'h1, rx, k[1]);
        i_host.byteIo(d, 1'h1, rx, k[0]);
        i_host.frame(1'h0);
        tick(10);
    endtask : wr
    task automatic wrOk(input logic [7:0] d);
        logic [1:0] k;
        wr(lnbc_pkg::I2C_BASE_ADDR | 7'(addrSel), d, k);
        chk("write ack", 8'h00, 8'(k));
    endtask : wrOk
    // Read: host acks the first byte and refuses the second.
    task automatic rd(input logic [7:0] exp);
        logic [7:0] r0, r1;
        logic a, b;
        i_host.frame(1'h1);
        i_host.byteIo({lnbc_pkg::I2C_BASE_ADDR | 7'(addrSel), 1'h1}, 1'h1, r0, a);
        i_host.byteIo(8'hff, 1'h0, r0, b);
        i_host.byteIo(8'hff, 1'h1, r1, b);
        i_host.frame(1'h0);
        chk("read ack", 8'h00, 8'(a));
        chk("read byte", exp, r0);
        chk("read again", exp, r1);
        tick(10);
    endtask : rd
    task automatic tCtrl();
        rd(8'h00);
        chk("power", 8'h00, pwr);
        wrOk(8'hff);
        rd(8'hfc);
        chk("power", 8'hcf, pwr);
        tonePin = 1'h1;
        tick(6);
        chk("power", 8'hdf, pwr);
        wrOk(8'h4c);
        chk("power", 8'hfa, pwr);
        tonePin = 1'h0;
        wrOk(8'h04);
        chk("power", 8'hc0, pwr);
        wrOk(8'h00);
        chk("power", 8'h00, pwr);
    endtask : tCtrl
    // Each address setting answers its own address and not the next one; slow host clock.
    task automatic tAddr();
        logic [1:0] k;
        i_host.halfNs = 240;
        for (int i = 0; i < 4; i++) begin
            addrSel = 2'(i);
            tick(6);
            wr(lnbc_pkg::I2C_BASE_ADDR | 7'(i), 8'h04, k);
            chk("own address", 8'h00, 8'(k));
            wr(lnbc_pkg::I2C_BASE_ADDR | 7'((i + 1) % 4), 8'h00, k);
            chk("other address", 8'h03, 8'(k));
        end
        addrSel = 2'h0;
        i_host.halfNs = 24;
        tick(6);
    endtask : tAddr
    task automatic tOvl();
        int n;
        n = 0;
        ovl = 1'h1;
        tick(10);
        chk("overload", 8'h01, 8'(olFlag));
        chk("power", 8'h80, pwr);
        while (pwr.regulatorEnable !== 1'h1 && n < 60) begin
            tick(1);
            n++;
        end
        chk("off time", 8'h01, 8'(n inside {[27:35]}));
        tick(8);
        chk("power", 8'h80, pwr);
        ovl = 1'h0;
        tick(100);
        chk("overload", 8'h00, 8'(olFlag));
        chk("power", 8'hc0, pwr);
        wrOk(8'h84);
        ovl = 1'h1;
        tick(10);
        rd(8'h85);
        chk("power", 8'hc1, pwr);
        ovl = 1'h0;
        tick(6);
        chk("overload", 8'h00, 8'(olFlag));
    endtask : tOvl
    task automatic tHeatUv();
        logic [1:0] k;
        wrOk(8'h04);
        ovt = 1'h1;
        tick(6);
        chk("power", 8'h00, pwr);
        chk("overtemp", 8'h01, 8'(otFlag));
        rd(8'h06);
        ovt = 1'h0;
        tick(6);
        chk("power", 8'hc0, pwr);
        chk("overtemp", 8'h00, 8'(otFlag));
        uvlo = 1'h1;
        tick(6);
        chk("power", 8'h00, pwr);
        wr(lnbc_pkg::I2C_BASE_ADDR, 8'h04, k);
        chk("lockout ack", 8'h03, 8'(k));
        uvlo = 1'h0;
        tick(6);
        rd(8'h00);
    endtask : tHeatUv
    // Reset for two cycles, then the scenarios.
    initial begin
        reset = 1'h1;
        tonePin = 1'h0;
        ovl = 1'h0;
        ovt = 1'h0;
        uvlo = 1'h0;
        addrSel = 2'h0;
        tick(2);
        reset = 1'h0;
        tick(4);
        tCtrl();
        tAddr();
        tOvl();
        tHeatUv();
        completeRun();
    end
endmodule : tb_lnbc_supply_ctrl
